// ### rtl/pin_sync.v
`timescale 1ns/100ps
`include "timer_defs.vh"

module pin_sync #(
    parameter WIDTH = 2
) (
    input wire mclk,
    input wire rst,
    input wire [WIDTH-1:0] pin,
    output wire [WIDTH-1:0] level,
    output wire [WIDTH-1:0] fall
);

// ----------------------------------------
// two-flop synchroniser and edge detect
// ----------------------------------------
// first stage is read by the second stage only
genvar i;
generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_bit
        reg meta_reg;
        reg sync_reg;
        reg last_reg;
        always @(posedge mclk)
        begin
            if (rst)
            begin
                meta_reg <= 1'b0;
                sync_reg <= 1'b0;
                last_reg <= 1'b0;
            end
            else
            begin
                meta_reg <= pin[i];
                sync_reg <= meta_reg;
                last_reg <= sync_reg;
            end
        end
        assign level[i] = sync_reg;
        assign fall[i] = last_reg & ~sync_reg;
    end
endgenerate

endmodule

// ### rtl/prescaler.v
`timescale 1ns/100ps
`include "timer_defs.vh"

module prescaler (
    input wire mclk,
    input wire rst,
    input wire [1:0] sel,
    input wire ext_clock_pin,
    output reg presc_tick,
    output reg div12_tick,
    output reg ext8_tick
);

reg [5:0] sys_cnt_reg;
reg [2:0] ext_cnt_reg;
wire [0:0] ext_level;
wire [0:0] ext_fall;
wire wrap48;
wire at4;
wire at12;
wire ext_wrap;

// ----------------------------------------
// external clock synchronised first
// ----------------------------------------
pin_sync #(.WIDTH(1)) u_ext_sync (
    .mclk(mclk),
    .rst(rst),
    .pin(ext_clock_pin),
    .level(ext_level),
    .fall(ext_fall)
);

// one shared counter gives /4, /12 and /48 in phase
assign wrap48 = (sys_cnt_reg == `DIV_SYS_MAX);
assign at4 = (sys_cnt_reg[1:0] == 2'h3);
assign at12 = (sys_cnt_reg == 6'h0b) | (sys_cnt_reg == 6'h17) |
              (sys_cnt_reg == 6'h23) | wrap48;
assign ext_wrap = ext_fall[0] & (ext_cnt_reg == `DIV_EXT_MAX);

always @(posedge mclk)
begin
    if (rst)
    begin
        sys_cnt_reg <= 6'h00;
        ext_cnt_reg <= 3'h0;
        presc_tick <= 1'b0;
        div12_tick <= 1'b0;
        ext8_tick <= 1'b0;
    end
    else
    begin
        sys_cnt_reg <= wrap48 ? 6'h00 : sys_cnt_reg + 6'h01;
        if (ext_fall[0])
            ext_cnt_reg <= ext_cnt_reg + 3'h1;
        div12_tick <= at12;
        ext8_tick <= ext_wrap; // [R10]
        case (sel) // [R9]
            `PRE_DIV12: presc_tick <= at12;
            `PRE_DIV4: presc_tick <= at4;
            `PRE_DIV48: presc_tick <= wrap48;
            default: presc_tick <= ext_wrap;
        endcase
    end
end

endmodule

// ### rtl/timer01.v
// Operation
// R1 - timer one gate set: counts only while run and gate input active; run and gate are ignored while timer zero is split
// R2 - timer zero gate set: counts only while run and gate input active
// R3 - timer one source 1 counts falling edges of its count pin; the internal tick is used instead while timer zero is split
// R4 - timer zero source 1 counts falling edges of its count pin
// R5 - timer one modes: 13-bit, 16-bit, 8-bit reload, inactive
// R6 - timer zero modes: 13-bit, 16-bit, 8-bit reload, two 8-bit counters
// R7 - timer one clock: prescaled when select 0, system clock when 1
// R8 - timer zero clock: prescaled when select 0, system clock when 1
// R9 - prescale field: /12, /4, /48, external clock /8
// R10 - external clock /8 synchronised before timers use it
// R11 - timer three high byte clock select acts in split mode only
// R12 - timer three low byte: system clock or external clock selection
// R13 - timer two high byte clock select acts in split mode only
// R14 - timer two low byte: system clock or external clock selection
// R15 - timer zero low byte readable, writable, resets to zero
// R16 - timer one low byte readable, writable, resets to zero
// R17 - timer zero high byte readable, writable, resets to zero
// R18 - 13-bit mode wraps from 0x1fff and sets overflow flag
// R19 - reload mode: low byte wraps, sets flag, reloads from high byte
// R20 - split mode: timer zero high byte uses timer one run and flag
// R21 - timer one high byte readable, writable, resets to zero
// R22 - count pins synchronised, one increment per falling edge
// R23 - count pin levels held at least two system clocks
`timescale 1ns/100ps
`include "timer_defs.vh"

module timer01 (
    input wire mclk,
    input wire rst,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    input wire timer_zero_count_pin,
    input wire timer_one_count_pin,
    input wire ext_gate_input_zero,
    input wire ext_gate_input_one,
    input wire ext_clock_pin,
    output reg timer_zero_overflow_flag,
    output reg timer_one_overflow_flag,
    output reg timer_two_low_tick,
    output reg timer_two_high_tick,
    output reg timer_three_low_tick,
    output reg timer_three_high_tick
);

// ----------------------------------------
// step of one timer, returns {overflow, high, low}
// ----------------------------------------
function [16:0] count_step;
    input [1:0] mode;
    input [7:0] lo;
    input [7:0] hi;
    reg [12:0] c13;
    reg [15:0] c16;
    begin
        c13 = {hi, lo[4:0]} + 13'h0001;
        c16 = {hi, lo} + 16'h0001;
        case (mode)
            `MODE_13BIT: // [R18]
                count_step = {&{hi, lo[4:0]}, c13[12:5], lo[7:5], c13[4:0]};
            `MODE_16BIT:
                count_step = {&{hi, lo}, c16};
            `MODE_RELOAD: // [R19]
                count_step = (&lo) ? {1'b1, hi, hi} : {1'b0, hi, lo + 8'h01};
            default:
                count_step = {&lo, hi, lo + 8'h01};
        endcase
    end
endfunction

// ----------------------------------------
// address match, shared by every write enable
// ----------------------------------------
function addr_hit;
    input [7:0] addr;
    input [7:0] ofs;
    begin
        addr_hit = (addr == ofs);
    end
endfunction

// ----------------------------------------
// gate level against its polarity bit, 1 means active high
// ----------------------------------------
function gate_active;
    input level;
    input pol;
    begin
        gate_active = ~(level ^ pol);
    end
endfunction

// ----------------------------------------
// registers
// ----------------------------------------
reg [7:0] mode_reg;
reg [7:0] clk_sel_reg;
reg [7:0] aux_reg;
reg t0_run_reg;
reg t1_run_reg;
reg [7:0] t0_lo_reg;
reg [7:0] t0_hi_reg;
reg [7:0] t1_lo_reg;
reg [7:0] t1_hi_reg;
reg [7:0] t0_lo_next;
reg [7:0] t0_hi_next;
reg [7:0] t1_lo_next;
reg [7:0] t1_hi_next;
reg [16:0] step0;
reg [16:0] step1;
reg tf0_set;
reg tf1_set;
reg [7:0] rdata_next;

// ----------------------------------------
// pin synchronisers and prescaler
// ----------------------------------------
wire [1:0] cnt_fall;
wire [1:0] gate_level;
wire presc_tick;
wire div12_tick;
wire ext8_tick;

pin_sync #(.WIDTH(2)) u_count_sync ( // [R22]
    .mclk(mclk),
    .rst(rst),
    .pin({timer_one_count_pin, timer_zero_count_pin}),
    .level(),
    .fall(cnt_fall)
);

pin_sync #(.WIDTH(2)) u_gate_sync (
    .mclk(mclk),
    .rst(rst),
    .pin({ext_gate_input_one, ext_gate_input_zero}),
    .level(gate_level),
    .fall()
);

prescaler u_prescaler (
    .mclk(mclk),
    .rst(rst),
    .sel(clk_sel_reg[`CKS_PRE_HI:`CKS_PRE_LO]),
    .ext_clock_pin(ext_clock_pin),
    .presc_tick(presc_tick),
    .div12_tick(div12_tick),
    .ext8_tick(ext8_tick)
);

// ----------------------------------------
// count enables
// ----------------------------------------
wire [1:0] mode0 = mode_reg[`MOD_T0_MODE_HI:`MOD_T0_MODE_LO];
wire [1:0] mode1 = mode_reg[`MOD_T1_MODE_HI:`MOD_T1_MODE_LO];
wire split0 = (mode0 == `MODE_SPLIT);

wire timer_zero_gate_enable_act = gate_active(gate_level[0], aux_reg[`AUX_G0_POL]);
wire timer_one_gate_enable_act = gate_active(gate_level[1], aux_reg[`AUX_G1_POL]);

wire t0_int_tick = clk_sel_reg[`CKS_T0] | presc_tick; // [R8]
wire t1_int_tick = clk_sel_reg[`CKS_T1] | presc_tick; // [R7]

wire t0_tick = mode_reg[`MOD_T0_SRC] ? cnt_fall[0] : t0_int_tick; // [R4]
wire t1_ext_ok = mode_reg[`MOD_T1_SRC] & ~split0;
wire t1_tick = t1_ext_ok ? cnt_fall[1] : t1_int_tick; // [R3]

wire t0_en = t0_run_reg & (~mode_reg[`MOD_T0_GATE] | timer_zero_gate_enable_act); // [R2]
wire t1_gated = t1_run_reg & (~mode_reg[`MOD_T1_GATE] | timer_one_gate_enable_act); // [R1]

// while timer zero is split, timer one runs by its mode alone
wire t1_en = (mode1 != `MODE_SPLIT) & (split0 | t1_gated); // [R5]

wire inc0 = t0_tick & t0_en;
wire inc1 = t1_tick & t1_en;
wire inc0_hi = split0 & t1_run_reg & t0_int_tick; // [R20]

// ----------------------------------------
// bus decode
// ----------------------------------------
wire wr_ctl = reg_wr & addr_hit(reg_addr, `OFS_CONTROL);
wire wr_mode = reg_wr & addr_hit(reg_addr, `OFS_MODE);
wire wr_t0l = reg_wr & addr_hit(reg_addr, `OFS_T0_LOW);
wire wr_t1l = reg_wr & addr_hit(reg_addr, `OFS_T1_LOW);
wire wr_t0h = reg_wr & addr_hit(reg_addr, `OFS_T0_HIGH);
wire wr_t1h = reg_wr & addr_hit(reg_addr, `OFS_T1_HIGH);
wire wr_cks = reg_wr & addr_hit(reg_addr, `OFS_CLK_SEL);
wire wr_aux = reg_wr & addr_hit(reg_addr, `OFS_AUX);

// ----------------------------------------
// counter next values
// ----------------------------------------
// a software write to a byte wins over a count in the same cycle
always @*
begin
    step0 = count_step(mode0, t0_lo_reg, t0_hi_reg); // [R6]
    step1 = count_step(mode1, t1_lo_reg, t1_hi_reg);
    t0_lo_next = t0_lo_reg;
    t0_hi_next = t0_hi_reg;
    t1_lo_next = t1_lo_reg;
    t1_hi_next = t1_hi_reg;
    tf0_set = 1'b0;
    tf1_set = 1'b0;
    if (inc0)
    begin
        t0_lo_next = step0[7:0];
        t0_hi_next = step0[15:8];
        tf0_set = step0[16];
    end
    if (inc0_hi)
    begin
        t0_hi_next = t0_hi_reg + 8'h01;
        tf1_set = &t0_hi_reg; // [R20]
    end
    if (inc1)
    begin
        t1_lo_next = step1[7:0];
        t1_hi_next = step1[15:8];
        // split timer zero owns the timer one flag
        if (!split0)
            tf1_set = step1[16];
    end
    if (wr_t0l)
        t0_lo_next = reg_wdata; // [R15]
    if (wr_t0h)
        t0_hi_next = reg_wdata; // [R17]
    if (wr_t1l)
        t1_lo_next = reg_wdata; // [R16]
    if (wr_t1h)
        t1_hi_next = reg_wdata; // [R21]
end

// ----------------------------------------
// read mux
// ----------------------------------------
always @*
begin
    case (reg_addr)
        `OFS_CONTROL: rdata_next = {timer_one_overflow_flag, t1_run_reg,
                                    timer_zero_overflow_flag, t0_run_reg, 4'h0};
        `OFS_MODE: rdata_next = mode_reg;
        `OFS_T0_LOW: rdata_next = t0_lo_reg;
        `OFS_T1_LOW: rdata_next = t1_lo_reg;
        `OFS_T0_HIGH: rdata_next = t0_hi_reg;
        `OFS_T1_HIGH: rdata_next = t1_hi_reg;
        `OFS_CLK_SEL: rdata_next = clk_sel_reg;
        `OFS_AUX: rdata_next = aux_reg;
        default: rdata_next = 8'h00;
    endcase
end

// ----------------------------------------
// timer two and three clock selection
// ----------------------------------------
reg t2_ext;
reg t3_ext;
reg t2_low;
reg t3_low;
reg t2_high;
reg t3_high;

// outside split mode the high byte select is ignored, so it follows the low byte
always @*
begin
    t2_ext = div12_tick;
    t3_ext = div12_tick;
    if (aux_reg[`AUX_T2_XCLK])
        t2_ext = ext8_tick;
    if (aux_reg[`AUX_T3_XCLK])
        t3_ext = ext8_tick;
    t2_low = clk_sel_reg[`CKS_T2_LOW] | t2_ext; // [R14]
    t3_low = clk_sel_reg[`CKS_T3_LOW] | t3_ext; // [R12]
    t2_high = t2_low;
    t3_high = t3_low;
    if (aux_reg[`AUX_T2_SPLIT])
        t2_high = clk_sel_reg[`CKS_T2_HIGH] | t2_ext; // [R13]
    if (aux_reg[`AUX_T3_SPLIT])
        t3_high = clk_sel_reg[`CKS_T3_HIGH] | t3_ext; // [R11]
end

// ----------------------------------------
// state update
// ----------------------------------------
always @(posedge mclk)
begin
    if (rst)
    begin
        mode_reg <= `REG_RESET;
        clk_sel_reg <= `REG_RESET;
        aux_reg <= `REG_RESET;
        t0_run_reg <= 1'b0;
        t1_run_reg <= 1'b0;
        t0_lo_reg <= `REG_RESET;
        t0_hi_reg <= `REG_RESET;
        t1_lo_reg <= `REG_RESET;
        t1_hi_reg <= `REG_RESET;
        timer_zero_overflow_flag <= 1'b0;
        timer_one_overflow_flag <= 1'b0;
        reg_rdata <= 8'h00;
        timer_two_low_tick <= 1'b0;
        timer_two_high_tick <= 1'b0;
        timer_three_low_tick <= 1'b0;
        timer_three_high_tick <= 1'b0;
    end
    else
    begin
        if (wr_mode)
            mode_reg <= reg_wdata;
        if (wr_cks)
            clk_sel_reg <= reg_wdata;
        if (wr_aux)
            aux_reg <= reg_wdata;
        if (wr_ctl)
        begin
            t0_run_reg <= reg_wdata[`CTL_T0_RUN];
            t1_run_reg <= reg_wdata[`CTL_T1_RUN];
        end
        t0_lo_reg <= t0_lo_next;
        t0_hi_reg <= t0_hi_next;
        t1_lo_reg <= t1_lo_next;
        t1_hi_reg <= t1_hi_next;
        // hardware set wins over a software clear
        if (tf0_set) // [R18]
            timer_zero_overflow_flag <= 1'b1;
        else if (wr_ctl)
            timer_zero_overflow_flag <= reg_wdata[`CTL_T0_FLAG];
        if (tf1_set) // [R19]
            timer_one_overflow_flag <= 1'b1;
        else if (wr_ctl)
            timer_one_overflow_flag <= reg_wdata[`CTL_T1_FLAG];
        if (reg_rd)
            reg_rdata <= rdata_next;
        else
            reg_rdata <= 8'h00;
        timer_two_low_tick <= t2_low;
        timer_two_high_tick <= t2_high;
        timer_three_low_tick <= t3_low;
        timer_three_high_tick <= t3_high;
    end
end

endmodule

// ### rtl/timer_defs.vh
`ifndef TIMER_DEFS_VH
`define TIMER_DEFS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_CONTROL 8'h88
`define OFS_MODE 8'h89
`define OFS_T0_LOW 8'h8a
`define OFS_T1_LOW 8'h8b
`define OFS_T0_HIGH 8'h8c
`define OFS_T1_HIGH 8'h8d
`define OFS_CLK_SEL 8'h8f
`define OFS_AUX 8'h90

// ----------------------------------------
// control register fields
// ----------------------------------------
`define CTL_T1_FLAG 7
`define CTL_T1_RUN 6
`define CTL_T0_FLAG 5
`define CTL_T0_RUN 4

// ----------------------------------------
// mode register fields
// ----------------------------------------
`define MOD_T1_GATE 7
`define MOD_T1_SRC 6
`define MOD_T1_MODE_HI 5
`define MOD_T1_MODE_LO 4
`define MOD_T0_GATE 3
`define MOD_T0_SRC 2
`define MOD_T0_MODE_HI 1
`define MOD_T0_MODE_LO 0

// ----------------------------------------
// clock select fields
// ----------------------------------------
`define CKS_T3_HIGH 7
`define CKS_T3_LOW 6
`define CKS_T2_HIGH 5
`define CKS_T2_LOW 4
`define CKS_T1 3
`define CKS_T0 2
`define CKS_PRE_HI 1
`define CKS_PRE_LO 0

// ----------------------------------------
// aux register fields
// ----------------------------------------
`define AUX_G0_POL 0
`define AUX_G1_POL 1
`define AUX_T2_XCLK 4
`define AUX_T2_SPLIT 5
`define AUX_T3_XCLK 6
`define AUX_T3_SPLIT 7

// ----------------------------------------
// modes, reset value, divisors
// ----------------------------------------
`define MODE_13BIT 2'h0
`define MODE_16BIT 2'h1
`define MODE_RELOAD 2'h2
`define MODE_SPLIT 2'h3
`define PRE_DIV12 2'h0
`define PRE_DIV4 2'h1
`define PRE_DIV48 2'h2
`define PRE_EXT8 2'h3
`define REG_RESET 8'h00
`define DIV_SYS_MAX 6'h2f
`define DIV_EXT_MAX 3'h7

`endif

// ### verif/ext_side.sv
`timescale 1ns/100ps
module ext_side (
    input logic mclk,
    output logic [2:0] pins,
    output logic [1:0] gates
);
// pins: 0 timer zero count, 1 timer one count, 2 external clock; idle high
initial
begin
    pins = 3'h7;
    gates = 2'h0;
end
task automatic set_gates(input logic [1:0] g);
    @(posedge mclk);
    gates <= g;
endtask
task automatic pulse(input int which, input int cnt);
    repeat (cnt)
    begin
        @(posedge mclk);
        pins[which] <= 1'b0;
        repeat (3) @(posedge mclk);
        pins[which] <= 1'b1;
        repeat (2) @(posedge mclk);
    end
endtask
endmodule

// ### verif/timer01_chk.sv
`timescale 1ns/100ps
module timer01_chk (
    input logic mclk,
    input logic rst,
    input logic [7:0] reg_addr,
    input logic [7:0] reg_wdata,
    input logic reg_wr,
    input logic reg_rd,
    input logic [7:0] reg_rdata,
    input logic timer_zero_count_pin,
    input logic timer_one_count_pin,
    input logic ext_gate_input_zero,
    input logic ext_gate_input_one,
    input logic ext_clock_pin,
    input logic timer_zero_overflow_flag,
    input logic timer_one_overflow_flag,
    input logic timer_two_low_tick,
    input logic timer_two_high_tick,
    input logic timer_three_low_tick,
    input logic timer_three_high_tick
);
// ------------------------------
// shadows of the select registers
// ------------------------------
// the ticks are registered, so the shadow one cycle old is what they follow
logic [7:0] cks_reg, cks_old_reg, aux_reg, aux_old_reg;
logic ctl_wr;
assign ctl_wr = reg_wr && reg_addr == 8'h88;
always @(posedge mclk)
begin
    cks_old_reg <= cks_reg;
    aux_old_reg <= aux_reg;
    if (rst)
    begin
        cks_reg <= 8'h00;
        aux_reg <= 8'h00;
    end
    else if (reg_wr && reg_addr == 8'h8f)
        cks_reg <= reg_wdata;
    else if (reg_wr && reg_addr == 8'h90)
        aux_reg <= reg_wdata;
end
default clocking @(posedge mclk); endclocking
default disable iff (rst);
// ------------------------------
// properties
// ------------------------------
AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
AST_CFG_BACK: assert property (reg_wr && reg_addr inside {8'h89, 8'h8f, 8'h90} ##1
    !reg_wr ##1 reg_rd && reg_addr == $past(reg_addr, 2) |=> reg_rdata == $past(reg_wdata, 3))
    else $error("config register read back wrong");
AST_CTL_FLAGS: assert property (reg_rd && reg_addr == 8'h88 |=>
    {reg_rdata[7], reg_rdata[5], reg_rdata[3:0]} ==
    {$past(timer_one_overflow_flag), $past(timer_zero_overflow_flag), 4'h0})
    else $error("control read does not show the flags");
AST_FLAG0_HOLD: assert property (timer_zero_overflow_flag && !ctl_wr |=>
    timer_zero_overflow_flag) else $error("timer zero flag dropped by itself");
AST_FLAG1_HOLD: assert property (timer_one_overflow_flag && !ctl_wr |=>
    timer_one_overflow_flag) else $error("timer one flag dropped by itself");
AST_T2L_FAST: assert property (cks_reg[4] && cks_old_reg[4] |-> timer_two_low_tick)
    else $error("timer two low tick not every cycle");
AST_T3L_FAST: assert property (cks_reg[6] && cks_old_reg[6] |-> timer_three_low_tick)
    else $error("timer three low tick not every cycle");
AST_T2H_SPLIT: assert property (aux_old_reg[5] && cks_old_reg[5] |-> timer_two_high_tick)
    else $error("timer two high tick not every cycle");
AST_T3H_SPLIT: assert property (aux_old_reg[7] && cks_old_reg[7] |-> timer_three_high_tick)
    else $error("timer three high tick not every cycle");
AST_T2L_SLOW: assert property ((!cks_reg[4] && !aux_reg[4]) [*4] |->
    !(timer_two_low_tick && $past(timer_two_low_tick)))
    else $error("divided tick came two cycles running");
endmodule
bind timer01 timer01_chk u_chk (
    .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer_zero_count_pin(timer_zero_count_pin),
    .timer_one_count_pin(timer_one_count_pin), .ext_gate_input_zero(ext_gate_input_zero),
    .ext_gate_input_one(ext_gate_input_one), .ext_clock_pin(ext_clock_pin),
    .timer_zero_overflow_flag(timer_zero_overflow_flag),
    .timer_one_overflow_flag(timer_one_overflow_flag),
    .timer_two_low_tick(timer_two_low_tick), .timer_two_high_tick(timer_two_high_tick),
    .timer_three_low_tick(timer_three_low_tick), .timer_three_high_tick(timer_three_high_tick)
);

// ### verif/timer01_tb.sv
`timescale 1ns/100ps
module timer01_tb;
logic mclk, rst, reg_wr, reg_rd, f0, f1;
logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
logic [2:0] pins;
logic [1:0] gates, fseen;
int err_total, samples_checked, cyc, seed, lo, hi, fl, n;
logic [7:0] ra [8] = '{8'h88, 8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'h8f, 8'h90, 8'h89};
int ex [4] = '{8, 24, 2, 2};
timer01 uut (
    .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer_zero_count_pin(pins[0]),
    .timer_one_count_pin(pins[1]), .ext_gate_input_zero(gates[0]),
    .ext_gate_input_one(gates[1]), .ext_clock_pin(pins[2]),
    .timer_zero_overflow_flag(f0), .timer_one_overflow_flag(f1), .timer_two_low_tick(),
    .timer_two_high_tick(), .timer_three_low_tick(), .timer_three_high_tick()
);
ext_side u_ext (.mclk(mclk), .pins(pins), .gates(gates));
always #2.5 mclk = ~mclk;
// flags are sticky here, since the stop write clears them in the design
always @(posedge mclk)
begin
    cyc <= cyc + 1;
    fseen <= fseen | {f1, f0};
    if (cyc == 20000)
    begin
        err_total++;
        report_and_stop;
    end
end
// ------------------------------
// bus and compare tasks
// ------------------------------
task automatic check(input string what, input logic [7:0] seen, exp);
    samples_checked++;
    if (seen !== exp)
    begin
        err_total++;
        $display("BAD %s expected %h seen %h", what, exp, seen);
    end
endtask
task automatic wr(input logic [7:0] a, d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
endtask
task automatic rc(input string w, input logic [7:0] a, exp);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 check(w, reg_rdata, exp);
endtask
// run bits high for exactly n count edges
task automatic run(input logic [7:0] go, input int n);
    wr(8'h88, go);
    repeat (n - 2) @(posedge mclk);
    wr(8'h88, 8'h00);
endtask
task automatic model(input int t, m, n, inout int lo, hi, output int fl);
    int w;
    fl = 0;
    w = (m == 0) ? hi * 32 + lo % 32 + n : hi * 256 + lo + n;
    if (m < 2)
    begin
        if (w >= (m == 0 ? 8192 : 65536))
            fl = t + 1;
        hi = m == 0 ? (w / 32) % 256 : (w / 256) % 256;
        lo = m == 0 ? (lo & 224) | w % 32 : w % 256;
    end
    else if (m == 2)
        repeat (n)
        begin
            fl = lo == 255 ? t + 1 : fl;
            lo = lo == 255 ? hi : lo + 1;
        end
    else if (t == 0)
    begin
        fl = (lo + n > 255) + 2 * (hi + n > 255);
        lo = (lo + n) % 256;
        hi = (hi + n) % 256;
    end
endtask
task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
        $display("Run complete: PASS");
    else
        $display("Run complete: FAIL");
    $finish;
endtask
// ------------------------------
// main sequence
// ------------------------------
initial
begin
    mclk = 1'b0;
    rst = 1'b1;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h0;
    {err_total, samples_checked, cyc, fseen} = 0;
    seed = 32'h50654587;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++)
        rc("reset value", ra[i], 8'h00);
    rc("unmapped", 8'h87, 8'h00);
    // mode written last: a random split mode could start timer one
    for (int i = 1; i < 8; i++)
    begin
        v = $random(seed);
        wr(ra[i], v);
        rc("read back", ra[i], v);
    end
    for (int t = 0; t < 2; t++)
        for (int m = 0; m < 4; m++)
        begin
            lo = 240 | ($random(seed) & 15);
            hi = ($random(seed) & 1) ? 255 : $random(seed) & 255;
            n = 4 + ($random(seed) & 15);
            wr(8'h88, 8'h00);
            wr(8'h8f, 8'h0c);
            wr(8'h89, 8'(m << (4 * t)));
            wr(8'h8a + 8'(t), 8'(lo));
            wr(8'h8c + 8'(t), 8'(hi));
            #1 fseen = 2'h0;
            run(t == 0 && m == 3 ? 8'h50 : 8'h10 << (2 * t), n);
            model(t, m, n, lo, hi, fl);
            rc("count low", 8'h8a + 8'(t), 8'(lo));
            rc("count high", 8'h8c + 8'(t), 8'(hi));
            check("flags", {6'h0, fseen}, 8'(fl));
        end
    for (int g = 0; g < 4; g++)
    begin
        wr(8'h90, g[0] ? 8'h03 : 8'h00);
        u_ext.set_gates({2{g[0] ~^ g[1]}});
        wr(8'h89, 8'h99);
        wr(8'h8a, 8'h00);
        wr(8'h8b, 8'h00);
        run(8'h50, 20);
        rc("gated zero", 8'h8a, g[1] ? 8'd20 : 8'd0);
        rc("gated one", 8'h8b, g[1] ? 8'd20 : 8'd0);
    end
    wr(8'h89, 8'h55);
    wr(8'h8a, 8'h00);
    wr(8'h8b, 8'h00);
    wr(8'h88, 8'h50);
    u_ext.pulse(0, 5);
    u_ext.pulse(1, 3);
    repeat (8) @(posedge mclk);
    wr(8'h88, 8'h00);
    rc("pin count zero", 8'h8a, 8'd5);
    rc("pin count one", 8'h8b, 8'd3);
    for (int f = 0; f < 4; f++)
    begin
        wr(8'h8f, 8'(f));
        wr(8'h89, 8'h11);
        wr(8'h8a, 8'h00);
        wr(8'h8b, 8'h00);
        wr(8'h88, 8'h50);
        if (f == 3)
            u_ext.pulse(2, 18);
        else
            repeat (94) @(posedge mclk);
        wr(8'h88, 8'h00);
        rc("prescaled zero", 8'h8a, 8'(ex[f]));
        rc("prescaled one", 8'h8b, 8'(ex[f]));
    end
    wr(8'h90, 8'ha0);
    wr(8'h8f, 8'hf0);
    repeat (6) @(posedge mclk);
    report_and_stop;
end
endmodule
